/* shared/tpw_pkg.sv */
// Purpose: constants and types for the phase-correct pwm timer block
// Assumes: 32-bit axi4-lite register access, byte-wide register data except the 11-bit control
// Notes:   offsets are byte addresses, one register per aligned word
package tpw_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CNT_HI = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CMA_HI = 8'h0C;
  localparam logic [7:0] OFS_CMA_LO = 8'h10;
  localparam logic [7:0] OFS_CMB_HI = 8'h14;
  localparam logic [7:0] OFS_CMB_LO = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1C;
  localparam logic [7:0] OFS_MASK   = 8'h20;
  localparam logic [7:0] OFS_GIE    = 8'h24;
  // ==========================================================
  // control field positions and reset values
  localparam int CTRL_PWM_LSB = 0;
  localparam int CTRL_COMA_LSB = 2;
  localparam int CTRL_COMB_LSB = 4;
  localparam int CTRL_CLR_BIT = 6;
  localparam int CTRL_CS_LSB  = 8;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [2:0]  STAT_RST = 3'h0;
  // status bit positions
  localparam int ST_OVF  = 0;
  localparam int ST_CMPA = 1;
  localparam int ST_CMPB = 2;
  // ==========================================================
  // top values per resolution
  localparam logic [15:0] TOP_8  = 16'h00FF;
  localparam logic [15:0] TOP_9  = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  // clock source select codes
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_DIV1  = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // prescaler masks: tick when all masked bits are one
  localparam logic [9:0] PRE_M8    = 10'h007;
  localparam logic [9:0] PRE_M64   = 10'h03F;
  localparam logic [9:0] PRE_M256  = 10'h0FF;
  localparam logic [9:0] PRE_M1024 = 10'h3FF;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  typedef enum logic [1:0] {PWM_OFF, PWM_8, PWM_9, PWM_10} tpw_pwm_t;
  typedef enum logic {DIR_UP, DIR_DOWN} tpw_dir_t;
endpackage

/* src/tpw_timer.sv */
// Purpose: 16-bit timer with dual phase-correct pwm, axi4-lite registers
// Assumes: single 100 MHz clock aclk, synchronous active-low aresetn
// Notes:   byte registers share one staging latch, see handover
// Notes on behaviour
// - pwm counts up to top, then down
// - top is 255, 511 or 1023
// - low ten compare bits drive pins
// - mode 10: up clears, down sets
// - mode 11: down clears, up sets
// - compare writes buffered in pwm, latched at top; in normal mode taken at once
// - compare read returns buffered value
// - zero compare, or top compare on undivided clock, gives fixed level
// - top compare undivided clock: no pulse
// - top compare prescaled: one-period pulse
// - overflow flag set leaving zero in pwm, on wrap from 0xFFFF otherwise
// - interrupt needs flag, enable, global enable
// - high byte staged, low byte commits
// - clock select: stop, divisors, external edges
// - clear-on-match-a ignored in pwm
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module tpw_timer
  import tpw_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic        ext_clock_pin,
  output logic [1:0]       compare_output,
  output logic [1:0]       compare_output_oe,
  output logic             irq
);
  // ==========================================================
  // state
  logic [10:0] ctrl_reg, ctrl_next;
  logic [15:0] cnt_reg, cnt_next;
  tpw_dir_t    dir_reg, dir_next;
  logic [7:0]  temp_reg, temp_next;
  logic [15:0] buf_reg [2];
  logic [15:0] buf_next [2];
  logic [15:0] act_reg [2];
  logic [15:0] act_next [2];
  logic [1:0]  out_reg, out_next, pend_reg, pend_next, oe_next;
  logic [2:0]  stat_reg, stat_next, mask_reg, mask_next;
  logic        gie_reg, gie_next, irq_next;
  logic [9:0]  pre_reg, pre_next;
  logic [2:0]  sync_reg;
  logic        lvl_reg, lvl_next, ext_rise, ext_fall;
  logic        awr_reg, awr_next, bval_reg, bval_next, arr_reg, arr_next;
  logic        rval_reg, rval_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // decoded helpers
  tpw_pwm_t    pmode;
  logic [2:0]  cs;
  logic        pwm, tick, moving_up, wr_go, rd_go, cnt_wr;
  logic [15:0] top;
  logic [1:0]  match, com;
  logic [2:0]  stat_set;
  logic [7:0]  wbyte;

  // ==========================================================
  // decode of control fields
  always_comb begin
    pmode = tpw_pwm_t'(ctrl_reg[CTRL_PWM_LSB +: 2]);
    cs    = ctrl_reg[CTRL_CS_LSB +: 3];
    pwm   = (pmode != PWM_OFF);
    unique case (pmode)
      PWM_8:   top = TOP_8;
      PWM_9:   top = TOP_9;
      PWM_10:  top = TOP_10;
      PWM_OFF: top = 16'hFFFF;
    endcase
    wr_go = s_axi_awvalid & s_axi_wvalid & ~awr_reg & ~bval_reg;
    rd_go = s_axi_arvalid & ~arr_reg & ~rval_reg;
    wbyte = s_axi_wdata[7:0];
  end

  // ==========================================================
  // external pin: three flops, edge once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], ext_clock_pin};
    end
  end

  // timer clock enable from prescaler or pin edge
  always_comb begin
    pre_next = pre_reg + 10'h001;
    lvl_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : lvl_reg;
    ext_rise = lvl_next & ~lvl_reg;
    ext_fall = ~lvl_next & lvl_reg;
    unique case (cs)
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (pre_reg & PRE_M8) == PRE_M8;
      CS_DIV64:    tick = (pre_reg & PRE_M64) == PRE_M64;
      CS_DIV256:   tick = (pre_reg & PRE_M256) == PRE_M256;
      CS_DIV1024:  tick = (pre_reg & PRE_M1024) == PRE_M1024;
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
    endcase
  end

  // ==========================================================
  // counter, channels, flags and register access
  always_comb begin
    ctrl_next = ctrl_reg;
    cnt_next  = cnt_reg;
    dir_next  = dir_reg;
    temp_next = temp_reg;
    buf_next  = buf_reg;
    act_next  = act_reg;
    out_next  = out_reg;
    pend_next = pend_reg;
    mask_next = mask_reg;
    gie_next  = gie_reg;
    stat_set  = 3'h0;
    match     = 2'h0;
    com       = 2'h0;
    cnt_wr    = wr_go & s_axi_wstrb[0] & (s_axi_awaddr == OFS_CNT_LO);
    // direction of travel into the next value
    moving_up = (dir_reg == DIR_UP) ? (cnt_reg != top) : (cnt_reg == 16'h0000);
    if (tick && pwm) begin
      unique case (dir_reg)
        DIR_UP: begin
          cnt_next = (cnt_reg == top) ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
          dir_next = (cnt_reg == top) ? DIR_DOWN : DIR_UP;
        end
        DIR_DOWN: begin
          cnt_next = (cnt_reg == 16'h0000) ? 16'h0001 : cnt_reg - 16'h0001;
          dir_next = (cnt_reg == 16'h0000) ? DIR_UP : DIR_DOWN;
        end
      endcase
      if (cnt_reg == 16'h0000) stat_set[ST_OVF] = 1'b1;
    end else if (tick) begin
      cnt_next = cnt_reg + 16'h0001;
      dir_next = DIR_UP;
      if (cnt_reg == 16'hFFFF) stat_set[ST_OVF] = 1'b1;
    end
    // per-channel compare; pins track only in pwm mode
    for (int ch = 0; ch < 2; ch++) begin
      com = ctrl_reg[CTRL_COMA_LSB + 2*ch +: 2];
      if (pwm) begin
        match[ch] = tick & (cnt_next[9:0] == act_reg[ch][9:0]);
      end else begin
        match[ch] = tick & (cnt_next == act_reg[ch]);
      end
      if (match[ch]) stat_set[ST_CMPA + ch] = 1'b1;
      if (match[ch] && pwm && com[1]) begin
        if (act_reg[ch][9:0] == 10'h000) begin
          out_next[ch] = com[0];
        end else if (act_reg[ch][9:0] == top[9:0]) begin
          if (cs == CS_DIV1) begin
            out_next[ch] = ~com[0];
          end else begin
            // alternate active and idle on each top arrival
            out_next[ch]  = pend_reg[ch] ? com[0] : ~com[0];
            pend_next[ch] = ~pend_reg[ch];
          end
        end else begin
          // com0 low: up clears, down sets; com0 high: the reverse
          out_next[ch] = moving_up ? com[0] : ~com[0];
        end
      end
      // buffered value moves to the comparator at top in pwm, every cycle otherwise
      if (!pwm || (tick && moving_up && cnt_next == top)) begin
        act_next[ch] = buf_reg[ch];
      end
    end
    // clear on match a works in normal mode only
    if (!pwm && match[0] && ctrl_reg[CTRL_CLR_BIT]) cnt_next = 16'h0000;
    // byte writes through the staging latch; control also takes bits 10:8
    if (wr_go && s_axi_wstrb[0]) begin
      unique case (s_axi_awaddr)
        OFS_CTRL:   ctrl_next = {s_axi_wdata[10:8], wbyte};
        OFS_CNT_HI, OFS_CMA_HI, OFS_CMB_HI: temp_next = wbyte;
        OFS_CNT_LO: begin
          cnt_next  = {temp_reg, wbyte};
          dir_next  = DIR_UP;
          pend_next = 2'h0;
        end
        OFS_CMA_LO: buf_next[0] = {temp_reg, wbyte};
        OFS_CMB_LO: buf_next[1] = {temp_reg, wbyte};
        OFS_MASK:   mask_next = wbyte[2:0];
        OFS_GIE:    gie_next = wbyte[0];
        default:    ;
      endcase
    end
    // write one to clear; a same-cycle event wins
    stat_next = stat_reg | stat_set;
    if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFS_STAT) begin
      stat_next = (stat_reg & ~wbyte[2:0]) | stat_set;
    end
    // low count read stages the high byte
    if (rd_go && s_axi_araddr == OFS_CNT_LO && !(wr_go && s_axi_wstrb[0])) begin
      temp_next = cnt_reg[15:8];
    end
    oe_next  = pwm ? {ctrl_reg[CTRL_COMB_LSB + 1], ctrl_reg[CTRL_COMA_LSB + 1]} : 2'h0;
    irq_next = gie_next & |(stat_next & mask_next);
  end

  // ==========================================================
  // axi handshake and read mux
  always_comb begin
    awr_next   = wr_go;
    bval_next  = bval_reg ? ~s_axi_bready : awr_reg;
    bresp_next = bresp_reg;
    arr_next   = rd_go;
    rval_next  = rval_reg ? ~s_axi_rready : arr_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (wr_go) begin
      unique case (s_axi_awaddr)
        OFS_CTRL, OFS_CNT_HI, OFS_CNT_LO, OFS_CMA_HI, OFS_CMA_LO,
        OFS_CMB_HI, OFS_CMB_LO, OFS_STAT, OFS_MASK, OFS_GIE: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      rresp_next = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:   rdata_next = {21'h0, ctrl_reg};
        OFS_CNT_LO: rdata_next = {24'h0, cnt_reg[7:0]};
        OFS_CNT_HI: rdata_next = {24'h0, temp_reg};
        OFS_CMA_LO: rdata_next = {24'h0, buf_reg[0][7:0]};
        OFS_CMA_HI: rdata_next = {24'h0, buf_reg[0][15:8]};
        OFS_CMB_LO: rdata_next = {24'h0, buf_reg[1][7:0]};
        OFS_CMB_HI: rdata_next = {24'h0, buf_reg[1][15:8]};
        OFS_STAT:   rdata_next = {29'h0, stat_reg};
        OFS_MASK:   rdata_next = {29'h0, mask_reg};
        OFS_GIE:    rdata_next = {31'h0, gie_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      cnt_reg  <= CNT_RST;
      dir_reg  <= DIR_UP;
      temp_reg <= 8'h00;
      buf_reg  <= '{CMP_RST, CMP_RST};
      act_reg  <= '{CMP_RST, CMP_RST};
      out_reg  <= 2'h0;
      pend_reg <= 2'h0;
      stat_reg <= STAT_RST;
      mask_reg <= STAT_RST;
      gie_reg  <= 1'b0;
      irq      <= 1'b0;
      compare_output_oe <= 2'h0;
      pre_reg  <= 10'h000;
      lvl_reg  <= 1'b0;
      awr_reg  <= 1'b0;
      bval_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arr_reg  <= 1'b0;
      rval_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      cnt_reg  <= cnt_next;
      dir_reg  <= dir_next;
      temp_reg <= temp_next;
      buf_reg  <= buf_next;
      act_reg  <= act_next;
      out_reg  <= out_next;
      pend_reg <= pend_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      gie_reg  <= gie_next;
      irq      <= irq_next;
      compare_output_oe <= oe_next;
      pre_reg  <= pre_next;
      lvl_reg  <= lvl_next;
      awr_reg  <= awr_next;
      bval_reg <= bval_next;
      bresp_reg <= bresp_next;
      arr_reg  <= arr_next;
      rval_reg <= rval_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flops
  assign compare_output = out_reg;
  assign s_axi_awready  = awr_reg;
  assign s_axi_wready   = awr_reg;
  assign s_axi_bvalid   = bval_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = arr_reg;
  assign s_axi_rvalid   = rval_reg;
  assign s_axi_rresp    = rresp_reg;
  assign s_axi_rdata    = rdata_reg;

  // ==========================================================
  // checks
  sequence s_turn;
    dir_reg == DIR_DOWN && cnt_reg == $past(cnt_reg) - 16'h0001;
  endsequence
  // a clock select change inside the gap ends the spacing promise
  sequence s_div8_gap;
    (!tick || cs != CS_DIV8)[*7] ##1 (tick || cs != CS_DIV8);
  endsequence
  property p_turn_at_top;
    @(posedge aclk) disable iff (!aresetn)
      pwm && tick && !cnt_wr && dir_reg == DIR_UP && cnt_reg == top |=> s_turn;
  endproperty
  a_turn_at_top: assert property (p_turn_at_top) else $error("no turn at top");
  property p_top_bound;
    @(posedge aclk) disable iff (!aresetn)
      pwm && !cnt_wr && ctrl_next == ctrl_reg && cnt_reg <= top |=> cnt_reg <= top;
  endproperty
  a_top_bound: assert property (p_top_bound) else $error("count beyond top");
  property p_noninv;
    @(posedge aclk) disable iff (!aresetn)
      match[0] && pwm && ctrl_reg[CTRL_COMA_LSB +: 2] == 2'h2 && moving_up
      && act_reg[0][9:0] != 10'h000 && act_reg[0][9:0] != top[9:0] |=> !compare_output[0];
  endproperty
  a_noninv: assert property (p_noninv) else $error("a not cleared on up match");
  property p_inv;
    @(posedge aclk) disable iff (!aresetn)
      match[1] && pwm && ctrl_reg[CTRL_COMB_LSB +: 2] == 2'h3 && !moving_up
      && act_reg[1][9:0] != 10'h000 && act_reg[1][9:0] != top[9:0] |=> !compare_output[1];
  endproperty
  a_inv: assert property (p_inv) else $error("b not cleared on down match");
  property p_latch;
    @(posedge aclk) disable iff (!aresetn)
      pwm && tick && !cnt_wr && moving_up && cnt_next == top |=> act_reg[0] == $past(buf_reg[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("compare not latched at top");
  property p_ovf;
    @(posedge aclk) disable iff (!aresetn)
      pwm && tick && cnt_reg == 16'h0000 |=> stat_reg[ST_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missed");
  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      irq == (gie_reg && (stat_reg & mask_reg) != 3'h0);
  endproperty
  a_irq: assert property (p_irq) else $error("irq disagrees with flags");
  property p_div8;
    @(posedge aclk) disable iff (!aresetn)
      tick && cs == CS_DIV8 && $stable(ctrl_reg) |=> s_div8_gap;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong");
  property p_pwm_no_clear;
    @(posedge aclk) disable iff (!aresetn)
      pwm && tick && !cnt_wr && dir_reg == DIR_UP && cnt_reg < top
      |=> cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_pwm_no_clear: assert property (p_pwm_no_clear) else $error("pwm count disturbed");
endmodule

/* verification/tpw_timer_tb.sv */
// Purpose: self-checking bench for the phase-correct pwm timer
// Assumes: axi4-lite master driven on rising edges, 100 MHz aclk
// Notes:   random compare values from a fixed seed, expectations from rules
`timescale 1ns/10ps
module tpw_timer_tb
  import tpw_pkg::*;
();
  // ==========================================================
  // signals
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        ext_clock_pin;
  logic [1:0]  compare_output;
  logic [1:0]  compare_output_oe;
  logic        irq;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  int          c, h, t0, t1, t2, n, ea;
  logic [31:0] d;
  logic [1:0]  r;
  logic [15:0] ca, nb, v1, v2, cv;
  logic [15:0] tops [3] = '{TOP_8, TOP_9, TOP_10};
  logic [2:0]  cs_tab [6] = '{CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
  int          dv_tab [6] = '{0, 1, 8, 64, 256, 1024};

  tpw_timer u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_clock_pin(ext_clock_pin),
    .compare_output(compare_output), .compare_output_oe(compare_output_oe), .irq(irq)
  );

  // ==========================================================
  // clock and hang guard; ceiling well above the planned run length
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic give_verdict();
    $display("counts: compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // range compare; an unknown value never counts as inside
  task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                     input logic [31:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // control word: mode, pin modes a and b, clear-on-match, clock select
  function automatic logic [31:0] ctl(input logic [1:0] pm, input logic [1:0] ma,
                                      input logic [1:0] mb, input logic [2:0] cs);
    ctl = {21'h0, cs, 1'b0, 1'b1, mb, ma, pm};
  endfunction

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dat;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (t >= 100) chk("write_answer", 0, 0, 1);
  endtask

  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t >= 100) chk("read_answer", 0, 0, 1);
  endtask

  // high byte first stages the latch, low byte commits both
  task automatic wr16(input logic [7:0] hi_a, input logic [15:0] v);
    wr(hi_a, {24'h0, v[15:8]});
    wr(hi_a + 8'h04, {24'h0, v[7:0]});
  endtask

  // low byte first so the high byte comes from the staged copy
  task automatic rd_cnt(output logic [15:0] v);
    logic [7:0] lo;
    rd(OFS_CNT_LO);
    lo = d[7:0];
    rd(OFS_CNT_HI);
    v = {d[7:0], lo};
  endtask

  task automatic wait_lvl(input int i, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge aclk);
      cnt++;
    end while (compare_output[i] !== lvl && cnt < 5000);
    if (cnt >= 5000) chk("pin_wait", 0, 0, 1);
  endtask

  task automatic cnt_high(input int i, input int len, output int hc);
    hc = 0;
    repeat (len) begin
      @(posedge aclk);
      if (compare_output[i] === 1'b1) hc++;
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, ext_clock_pin} = '0;
    aresetn = 1'b0;
    void'($urandom(32'h097F));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped place, control readback
    rd(OFS_CTRL);  chk("ctrl_reset", 0, 0, d);
    rd(OFS_STAT);  chk("stat_reset", 0, 0, d);
    rd(OFS_CNT_LO); chk("cnt_reset", 0, 0, d);
    rd(8'h30);     chk("unmapped_rresp", RESP_SLVERR, RESP_SLVERR, r);
    wr(8'h30, 32'h5A); chk("unmapped_bresp", RESP_SLVERR, RESP_SLVERR, r);
    v1 = 16'($urandom & 32'h7FF);
    wr(OFS_CTRL, {16'h0, v1});
    rd(OFS_CTRL);
    chk("ctrl_readback", {16'h0, v1}, {16'h0, v1}, d);
    $display("test registers done");
    // duty of both channels, 8-bit, undivided clock, clear-on-match set
    ca = 16'(20 + $urandom % 180);
    wr16(OFS_CMA_HI, ca);
    wr16(OFS_CMB_HI, ca);
    rd(OFS_CMA_HI);
    chk("cmpa_hi", ca[15:8], ca[15:8], d);
    wr(OFS_CTRL, ctl(PWM_8, 2'b10, 2'b11, CS_DIV1));
    repeat (1100) @(posedge aclk);
    chk("oe_on", 3, 3, compare_output_oe);
    cnt_high(0, 510, h);
    chk("duty_a", 2 * ca, 2 * ca, h);
    cnt_high(1, 510, h);
    chk("duty_b", 510 - 2 * ca, 510 - 2 * ca, h);
    rd_cnt(v1);
    chk("count_top", 0, 255, v1);
    $display("test duty done");
    // compare written in mid-period only takes effect after top
    nb = 16'(20 + $urandom % 180);
    wait_lvl(0, 1'b0, c);
    wait_lvl(0, 1'b1, c);
    t0 = cyc;
    wr16(OFS_CMA_HI, nb);
    rd(OFS_CMA_LO);
    chk("cmpa_buffered", nb[7:0], nb[7:0], d);
    wait_lvl(0, 1'b0, c);
    t1 = cyc;
    chk("high_old", 2 * ca, 2 * ca, t1 - t0);
    wait_lvl(0, 1'b1, c);
    t2 = cyc;
    chk("low_mixed", 510 - ca - nb, 510 - ca - nb, t2 - t1);
    $display("test buffering done");
    // period for each resolution
    for (int m = 1; m <= 3; m++) begin
      wr(OFS_CTRL, ctl(2'(m), 2'b10, 2'b11, CS_DIV1));
      repeat (2) begin
        wait_lvl(0, 1'b0, c);
        wait_lvl(0, 1'b1, c);
      end
      wait_lvl(0, 1'b0, c);
      wait_lvl(0, 1'b1, h);
      chk("period", 2 * tops[m-1], 2 * tops[m-1], c + h);
    end
    $display("test resolutions done");
    // zero compare undivided, top compare undivided and prescaled
    for (int k = 0; k < 3; k++) begin
      cv = (k == 0) ? 16'h0000 : TOP_8;
      n  = (k == 2) ? 8160 : 510;
      ea = (k == 0) ? 0 : ((k == 1) ? n : n / 2);
      // stop and rewind first: a count left above the new top would climb to wrap
      wr(OFS_CTRL, ctl(PWM_OFF, 2'b10, 2'b11, CS_STOP));
      wr16(OFS_CMA_HI, cv);
      wr16(OFS_CMB_HI, cv);
      wr16(OFS_CNT_HI, 16'h0000);
      wr(OFS_CTRL, ctl(PWM_8, 2'b10, 2'b11, (k == 2) ? CS_DIV8 : CS_DIV1));
      repeat (n + 1100) @(posedge aclk);
      cnt_high(0, n, h);
      chk("fixed_a", ea, ea, h);
      cnt_high(1, n, h);
      chk("fixed_b", n - ea, n - ea, h);
    end
    $display("test fixed levels done");
    // flags, mask and global enable
    wr16(OFS_CMA_HI, ca);
    wr16(OFS_CMB_HI, ca);
    wr(OFS_CTRL, ctl(PWM_8, 2'b10, 2'b11, CS_DIV1));
    wr(OFS_MASK, 0); wr(OFS_GIE, 1); wr(OFS_STAT, 7);
    repeat (600) @(posedge aclk);
    rd(OFS_STAT);
    chk("flags_set", 7, 7, d);
    chk("irq_masked", 0, 0, irq);
    wr(OFS_MASK, 1);
    repeat (3) @(posedge aclk);
    chk("irq_on", 1, 1, irq);
    wr(OFS_GIE, 0);
    repeat (3) @(posedge aclk);
    chk("irq_gie_off", 0, 0, irq);
    wr(OFS_GIE, 1);
    wr(OFS_MASK, 6);
    repeat (3) @(posedge aclk);
    chk("irq_match", 1, 1, irq);
    wr(OFS_CTRL, ctl(PWM_8, 2'b10, 2'b11, CS_STOP));
    wr(OFS_STAT, 7);
    rd(OFS_STAT);
    chk("flags_clear", 0, 0, d);
    repeat (3) @(posedge aclk);
    chk("irq_cleared", 0, 0, irq);
    // interrupts stay off while the shared staging latch is in use below
    wr(OFS_GIE, 0);
    $display("test interrupts done");
    // undriven pin modes
    wr(OFS_CTRL, ctl(PWM_8, 2'b01, 2'b00, CS_DIV1));
    repeat (3) @(posedge aclk);
    chk("oe_mode01", 0, 0, compare_output_oe);
    wr(OFS_CTRL, ctl(PWM_OFF, 2'b10, 2'b11, CS_DIV1));
    repeat (3) @(posedge aclk);
    chk("oe_pwm_off", 0, 0, compare_output_oe);
    $display("test pin enables done");
    // compare a parked high: clear-on-match must not rewind the count here
    wr16(OFS_CMA_HI, 16'hFFF0);
    // clock sources: samples lie eight source periods plus eight bus cycles apart
    for (int k = 0; k < 6; k++) begin
      wr(OFS_CTRL, ctl(PWM_OFF, 2'b00, 2'b00, cs_tab[k]));
      rd_cnt(v1);
      repeat ((k == 0) ? 100 : 8 * dv_tab[k]) @(posedge aclk);
      rd_cnt(v2);
      t0 = (k == 0) ? 0 : 8 + 8 / dv_tab[k];
      t1 = (k == 0) ? 0 : 8 + (dv_tab[k] + 7) / dv_tab[k];
      chk("ticks", t0, t1, v2 - v1);
    end
    for (int k = 6; k < 8; k++) begin
      wr(OFS_CTRL, ctl(PWM_OFF, 2'b00, 2'b00, 3'(k)));
      rd_cnt(v1);
      repeat (8) begin
        ext_clock_pin <= 1'b1;
        repeat (10) @(posedge aclk);
        ext_clock_pin <= 1'b0;
        repeat (10) @(posedge aclk);
      end
      rd_cnt(v2);
      chk("ext_ticks", 7, 9, v2 - v1);
    end
    $display("test clock select done");
    give_verdict();
  end
endmodule
